// ===== dv/tcomp_port_model.sv
`timescale 1ns/1ns
module tcomp_port_model (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic load,
	input wire logic [5:0] pin_out,
	input wire logic [5:0] pin_oe_n,
	output logic [5:0] port_data,
	output logic [5:0] pad
);
	// Port register takes a fresh value while load is high
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			port_data <= 6'h00;
		end else if (load) begin
			port_data <= 6'($urandom);
		end
	end
	// A released pin rises to its pull-up
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			pad[i] = pin_oe_n[i] ? 1'h1 : pin_out[i];
		end
	end
endmodule : tcomp_port_model

// ===== dv/timer16_compare_output_mode_tb.sv
`timescale 1ns/1ns
module timer16_compare_output_mode_tb;
	logic ref_clk = 1'h0;
	logic nrst = 1'h0;
	logic awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
	logic [7:0] awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0000_0000;
	logic awr, wr, bv, arr, rv;
	logic load = 1'h0;
	logic [1:0] br, rr;
	logic [31:0] rd;
	logic [1:0][15:0] cnt = '0;
	logic [1:0][15:0] top;
	logic [1:0] tick = 2'h0, up = 2'h0;
	logic [5:0] pin_out, pin_oe_n, pdat, pad;
	logic [33:0] exp_r [$];
	logic [1:0] exp_b [$];
	int num_errors = 0;
	int checks_done = 0;
	logic [3:0] wm;
	logic [1:0] md [3];
	logic [15:0] cmpv [3] = '{16'h0040, 16'h0080, 16'h00C0};
	logic [2:0] oc_r = 3'h0;
	logic [5:0] dir_r = 6'h00;
	assign top = {16'h00C0, 16'h00C0};
	always #10 ref_clk = ~ref_clk;

	tcomp_top i_dut (
		.ref_clk(ref_clk), .nrst(nrst),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
		.s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
		.s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
		.s_axi_rvalid(rv), .s_axi_rready(rry),
		.tmr_count(cnt), .tmr_top(top), .tmr_tick(tick),
		.tmr_count_up(up), .port_data(pdat),
		.pin_out(pin_out), .pin_oe_n(pin_oe_n)
	);
	tcomp_port_model i_port (
		.ref_clk(ref_clk), .nrst(nrst), .load(load), .pin_out(pin_out),
		.pin_oe_n(pin_oe_n), .port_data(pdat), .pad(pad)
	);

	task automatic wrap_up;
		$display("mismatches %0d of %0d checks", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : wrap_up

	task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : cmp

	task automatic bail(input int n);
		if (n >= 50) begin
			num_errors++;
			wrap_up();
		end
	endtask : bail

	// Bus answers are matched against the oldest pending note
	always @(posedge ref_clk) begin
		if (bv && bry)
			cmp({32'h0, br}, {32'h0, exp_b.pop_front()});
		if (rv && rry)
			cmp({rr, rd}, exp_r.pop_front());
	end

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d,
			input logic [1:0] er);
		bit ad, dd;
		int n;
		ad = 0;
		dd = 0;
		n = 0;
		exp_b.push_back(er);
		awa <= a;
		wd <= d;
		awv <= 1'h1;
		wv <= 1'h1;
		bry <= 1'h1;
		while (!(ad && dd) && n < 50) begin
			@(posedge ref_clk);
			n++;
			if (awr && !ad) begin
				ad = 1;
				awv <= 1'h0;
			end
			if (wr && !dd) begin
				dd = 1;
				wv <= 1'h0;
			end
		end
		while (!bv && n < 50) begin
			@(posedge ref_clk);
			n++;
		end
		bail(n);
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] a, input logic [33:0] e);
		int n;
		n = 0;
		exp_r.push_back(e);
		ara <= a;
		arv <= 1'h1;
		rry <= 1'h1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (!arr && n < 50);
		arv <= 1'h0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (!rv && n < 50);
		bail(n);
	endtask : rd_reg

	function automatic int cls_of(input logic [3:0] m);
		case (m)
			4'h0, 4'h4, 4'hC: return 0;
			4'h5, 4'h6, 4'h7, 4'hE, 4'hF: return 1;
			4'hD: return 3;
			default: return 2;
		endcase
	endfunction : cls_of

	function automatic logic conn_of(input int i);
		if (md[i] == 2'h0)
			return 1'h0;
		if (md[i] == 2'h1 && cls_of(wm) inside {1, 2})
			return wm[3] && i == 0;
		return 1'h1;
	endfunction : conn_of

	// One timer cycle on timer 1, mirrored in the reference outputs
	task automatic step(input logic [15:0] c, input logic u, input logic t);
		cnt[0] <= c;
		up[0] <= u;
		tick[0] <= t;
		cnt[1] <= 16'($urandom);
		@(posedge ref_clk);
		tick[0] <= 1'h0;
		for (int i = 0; i < 3; i++) begin
			logic mt, tp;
			mt = t && c == cmpv[i];
			tp = t && c == 16'h00C0;
			case (cls_of(wm))
				0: if (mt) oc_r[i] = md[i] == 2'h1 ? ~oc_r[i] : md[i][0];
				1: begin
					if (md[i][1] && tp)
						oc_r[i] = ~md[i][0];
					else if (md[i][1] && mt)
						oc_r[i] = md[i][0];
					else if (mt && conn_of(i))
						oc_r[i] = ~oc_r[i];
				end
				2: begin
					if (md[i][1] && mt)
						oc_r[i] = md[i][0] ^ ~u;
					else if (mt && conn_of(i))
						oc_r[i] = ~oc_r[i];
				end
				default: ;
			endcase
		end
	endtask : step

	task automatic check_all;
		logic [5:0] cn, pv;
		for (int i = 0; i < 6; i++) begin
			cn[i] = i < 3 ? conn_of(i) : 1'h0;
			pv[i] = cn[i] ? oc_r[i % 3] : pdat[i];
		end
		rd_reg(tcomp_pkg::OFS_OUT_STAT, {20'h0, cn, 5'h0, oc_r});
		cmp({28'h0, pin_oe_n}, {28'h0, ~dir_r});
		cmp({28'h0, pin_out}, {28'h0, pv});
		cmp({28'h0, pad}, {28'h0, ~dir_r | pv});
	endtask : check_all

	initial begin
		logic [7:0] rst_a [5];
		logic [7:0] v;
		int k;
		void'($urandom(79583));
		rst_a = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h20};
		repeat (16) @(posedge ref_clk);
		nrst <= 1'h1;
		@(posedge ref_clk);
		foreach (rst_a[j]) rd_reg(rst_a[j], 34'h0);
		v = 8'($urandom);
		wr_reg(tcomp_pkg::OFS_CTRL_A3, {24'h0, v}, tcomp_pkg::RESP_OKAY);
		rd_reg(tcomp_pkg::OFS_CTRL_A3, {26'h0, v});
		wr_reg(tcomp_pkg::OFS_CTRL_A3, 32'h0, tcomp_pkg::RESP_OKAY);
		rd_reg(8'h18, {tcomp_pkg::RESP_SLVERR, 32'h0});
		wr_reg(tcomp_pkg::OFS_OUT_STAT, 32'hFFFF_FFFF, tcomp_pkg::RESP_SLVERR);
		for (int i = 0; i < 3; i++)
			wr_reg(tcomp_pkg::OFS_CMP_BASE + 8'(4 * i), {16'h0, cmpv[i]},
				tcomp_pkg::RESP_OKAY);
		for (int m = 0; m < 16; m++) begin
			wm = 4'(m);
			md[0] = 2'($urandom_range(3, 1));
			md[1] = 2'($urandom_range(3, 1));
			md[2] = 2'($urandom_range(3, 2));
			dir_r = 6'($urandom);
			load <= 1'h1;
			wr_reg(tcomp_pkg::OFS_WGM_HI1, {30'h0, wm[3:2]}, 2'h0);
			load <= 1'h0;
			v = {md[0], md[1], md[2], wm[1:0]};
			wr_reg(tcomp_pkg::OFS_CTRL_A1, {24'h0, v}, 2'h0);
			rd_reg(tcomp_pkg::OFS_CTRL_A1, {26'h0, v});
			wr_reg(tcomp_pkg::OFS_PORT_DIR, {26'h0, dir_r}, 2'h0);
			repeat (12) begin
				k = $urandom_range(3);
				step(k == 3 ? 16'($urandom_range(255)) : cmpv[k],
					1'($urandom), 1'($urandom_range(3) != 0));
				check_all();
			end
		end
		wrap_up();
	end
endmodule : timer16_compare_output_mode_tb

// ===== src/tcomp_chan.sv
`timescale 1ns/1ns
module tcomp_chan (
	input wire logic ref_clk,
	input wire logic nrst,
	tcomp_chan_if.chan ch
);
	logic pwm;
	logic next_oc;

	assign pwm = (ch.wclass == tcomp_pkg::TCOMP_FAST)
		|| (ch.wclass == tcomp_pkg::TCOMP_PHASE);
	// Pin takeover; 01 in PWM classes only drives channel A with high bit
	assign ch.connect = (ch.mode != tcomp_pkg::MODE_OFF)
		&& !(pwm && ch.mode == tcomp_pkg::MODE_TOGGLE
		&& !(ch.wgm_hi && ch.is_a));

	always_comb begin
		next_oc = ch.oc;
		unique case (ch.wclass)
			tcomp_pkg::TCOMP_NON_PWM: begin
				if (ch.match) begin
					unique case (ch.mode)
						tcomp_pkg::MODE_OFF: next_oc = ch.oc;
						tcomp_pkg::MODE_TOGGLE: next_oc = !ch.oc;
						tcomp_pkg::MODE_LOW: next_oc = 1'b0;
						tcomp_pkg::MODE_HIGH: next_oc = 1'b1;
					endcase
				end
			end
			tcomp_pkg::TCOMP_FAST: begin
				if (ch.mode[1]) begin
					if (ch.at_top) begin
						next_oc = !ch.mode[0];
					end else if (ch.match && !ch.cmp_is_top) begin
						next_oc = ch.mode[0];
					end
				end else if (ch.mode[0] && ch.wgm_hi && ch.is_a && ch.match) begin
					next_oc = !ch.oc;
				end
			end
			tcomp_pkg::TCOMP_PHASE: begin
				if (ch.mode[1] && ch.match) begin
					next_oc = ch.count_up ? ch.mode[0] : !ch.mode[0];
				end else if (ch.mode[0] && ch.wgm_hi && ch.is_a && ch.match) begin
					next_oc = !ch.oc;
				end
			end
			tcomp_pkg::TCOMP_RESERVED: next_oc = ch.oc;
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ch.oc <= 1'b0;
		end else begin
			ch.oc <= next_oc;
		end
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	chk_off_disconnect: assert property (
		(ch.mode == tcomp_pkg::MODE_OFF) |-> !ch.connect)
		else $error("mode 00 still takes the pin");
	chk_nonpwm_toggle: assert property (
		(ch.match && ch.wclass == tcomp_pkg::TCOMP_NON_PWM
		&& ch.mode == tcomp_pkg::MODE_TOGGLE) |=> (ch.oc != $past(ch.oc)))
		else $error("no toggle on match");
	chk_nonpwm_clear: assert property (
		(ch.match && ch.wclass == tcomp_pkg::TCOMP_NON_PWM
		&& ch.mode == tcomp_pkg::MODE_LOW) |=> !ch.oc)
		else $error("no clear on match");
	chk_nonpwm_set: assert property (
		(ch.match && ch.wclass == tcomp_pkg::TCOMP_NON_PWM
		&& ch.mode == tcomp_pkg::MODE_HIGH) |=> ch.oc)
		else $error("no set on match");
	chk_pwm_toggle_gate: assert property (
		(pwm && ch.mode == tcomp_pkg::MODE_TOGGLE && !(ch.wgm_hi && ch.is_a))
		|-> !ch.connect)
		else $error("mode 01 connected in PWM");
	chk_fast_top_action: assert property (
		(ch.at_top && ch.wclass == tcomp_pkg::TCOMP_FAST && ch.mode[1])
		|=> (ch.oc == !$past(ch.mode[0])))
		else $error("wrong action at top");
	chk_fast_match_action: assert property (
		(ch.match && !ch.at_top && ch.wclass == tcomp_pkg::TCOMP_FAST
		&& ch.mode[1]) |=> (ch.oc == $past(ch.mode[0])))
		else $error("wrong action on fast match");
	chk_top_match_drop: assert property (
		(ch.match && ch.cmp_is_top && ch.wclass == tcomp_pkg::TCOMP_FAST
		&& ch.mode == tcomp_pkg::MODE_LOW) |=> ch.oc)
		else $error("match at top not ignored");
	chk_phase_match: assert property (
		(ch.match && ch.wclass == tcomp_pkg::TCOMP_PHASE && ch.mode[1])
		|=> (ch.oc == ($past(ch.mode[0]) ^ !$past(ch.count_up))))
		else $error("wrong dual-slope action");
endmodule : tcomp_chan

// ===== src/tcomp_chan_if.sv
`timescale 1ns/1ns
interface tcomp_chan_if;
	logic [1:0] mode;
	tcomp_pkg::tcomp_class_t wclass;
	logic wgm_hi;
	logic is_a;
	logic match;
	logic at_top;
	logic cmp_is_top;
	logic count_up;
	logic tick;
	logic oc;
	logic connect;
	modport ctl (
		output mode, wclass, wgm_hi, is_a, match, at_top, cmp_is_top,
		output count_up, tick,
		input oc, connect
	);
	modport chan (
		input mode, wclass, wgm_hi, is_a, match, at_top, cmp_is_top,
		input count_up, tick,
		output oc, connect
	);
endinterface : tcomp_chan_if

// ===== src/tcomp_pkg.sv
package tcomp_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL_A1 = 8'h00;
	localparam logic [7:0] OFS_CTRL_A3 = 8'h04;
	localparam logic [7:0] OFS_WGM_HI1 = 8'h08;
	localparam logic [7:0] OFS_WGM_HI3 = 8'h0C;
	localparam logic [7:0] OFS_PORT_DIR = 8'h10;
	localparam logic [7:0] OFS_OUT_STAT = 8'h14;
	localparam logic [7:0] OFS_CMP_BASE = 8'h20;
	localparam logic [7:0] OFS_CMP_LAST = 8'h34;
	// Field positions inside control register A and the output status register
	localparam int MODE_MSB [3] = '{7, 5, 3};
	localparam int WGM_LO_MSB = 1;
	localparam int STAT_CONN_LSB = 8;
	// Reset values
	localparam logic [7:0] RST_CTRL_A = 8'h00;
	localparam logic [1:0] RST_WGM_HI = 2'h0;
	localparam logic [5:0] RST_PORT_DIR = 6'h00;
	localparam logic [15:0] RST_CMP = 16'h0000;
	// Output mode field encodings
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_TOGGLE = 2'h1;
	localparam logic [1:0] MODE_LOW = 2'h2;
	localparam logic [1:0] MODE_HIGH = 2'h3;
	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		TCOMP_NON_PWM,
		TCOMP_FAST,
		TCOMP_PHASE,
		TCOMP_RESERVED
	} tcomp_class_t;
endpackage : tcomp_pkg

// ===== src/tcomp_top.sv
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
module tcomp_top (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [1:0][15:0] tmr_count,
	input wire logic [1:0][15:0] tmr_top,
	input wire logic [1:0] tmr_tick,
	input wire logic [1:0] tmr_count_up,
	input wire logic [5:0] port_data,
	output logic [5:0] pin_out,
	output logic [5:0] pin_oe_n
);
	logic [1:0][7:0] ctrl_a;
	logic [1:0][1:0] wgm_hi;
	logic [5:0] port_dir;
	logic [5:0][15:0] cmp_val;
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;
	logic wr_ok;
	logic [7:0] wr_off;
	logic [7:0] rd_off;
	logic [31:0] next_rdata;
	logic rd_ok;
	logic [5:0] oc_bits;
	logic [5:0] conn_bits;
	tcomp_pkg::tcomp_class_t wclass [2];

	function automatic logic is_cmp(input logic [7:0] a);
		return (a >= tcomp_pkg::OFS_CMP_BASE) && (a <= tcomp_pkg::OFS_CMP_LAST)
			&& (a[1:0] == 2'h0);
	endfunction : is_cmp

	// Write address channel
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_awready <= 1'b1;
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_awready <= 1'b1;
			end
			if (do_write) begin
				aw_held <= 1'b0;
			end
		end
	end

	// Write data channel
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_wready <= 1'b1;
			w_held <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else begin
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_wready <= 1'b1;
			end
			if (do_write) begin
				w_held <= 1'b0;
			end
		end
	end

	assign do_write = aw_held && w_held && !s_axi_bvalid;
	assign wr_off = aw_addr - tcomp_pkg::OFS_CMP_BASE;
	assign wr_ok = (aw_addr == tcomp_pkg::OFS_CTRL_A1)
		|| (aw_addr == tcomp_pkg::OFS_CTRL_A3)
		|| (aw_addr == tcomp_pkg::OFS_WGM_HI1)
		|| (aw_addr == tcomp_pkg::OFS_WGM_HI3)
		|| (aw_addr == tcomp_pkg::OFS_PORT_DIR)
		|| is_cmp(aw_addr);

	// Write response channel
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= tcomp_pkg::RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_ok ? tcomp_pkg::RESP_OKAY : tcomp_pkg::RESP_SLVERR;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Control, waveform high bits and direction registers
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_a <= {2{tcomp_pkg::RST_CTRL_A}};
			wgm_hi <= {2{tcomp_pkg::RST_WGM_HI}};
			port_dir <= tcomp_pkg::RST_PORT_DIR;
		end else if (do_write && w_strb[0]) begin
			if (aw_addr == tcomp_pkg::OFS_CTRL_A1) begin
				ctrl_a[0] <= w_data[7:0];
			end
			if (aw_addr == tcomp_pkg::OFS_CTRL_A3) begin
				ctrl_a[1] <= w_data[7:0];
			end
			if (aw_addr == tcomp_pkg::OFS_WGM_HI1) begin
				wgm_hi[0] <= w_data[1:0];
			end
			if (aw_addr == tcomp_pkg::OFS_WGM_HI3) begin
				wgm_hi[1] <= w_data[1:0];
			end
			if (aw_addr == tcomp_pkg::OFS_PORT_DIR) begin
				port_dir <= w_data[5:0];
			end
		end
	end

	// Compare value registers, two byte lanes each
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cmp_val <= {6{tcomp_pkg::RST_CMP}};
		end else if (do_write && is_cmp(aw_addr)) begin
			if (w_strb[0]) begin
				cmp_val[wr_off[4:2]][7:0] <= w_data[7:0];
			end
			if (w_strb[1]) begin
				cmp_val[wr_off[4:2]][15:8] <= w_data[15:8];
			end
		end
	end

	// Read data selection
	assign rd_off = s_axi_araddr - tcomp_pkg::OFS_CMP_BASE;
	always_comb begin
		next_rdata = 32'h0000_0000;
		rd_ok = 1'b1;
		if (s_axi_araddr == tcomp_pkg::OFS_CTRL_A1) begin
			next_rdata[7:0] = ctrl_a[0];
		end else if (s_axi_araddr == tcomp_pkg::OFS_CTRL_A3) begin
			next_rdata[7:0] = ctrl_a[1];
		end else if (s_axi_araddr == tcomp_pkg::OFS_WGM_HI1) begin
			next_rdata[1:0] = wgm_hi[0];
		end else if (s_axi_araddr == tcomp_pkg::OFS_WGM_HI3) begin
			next_rdata[1:0] = wgm_hi[1];
		end else if (s_axi_araddr == tcomp_pkg::OFS_PORT_DIR) begin
			next_rdata[5:0] = port_dir;
		end else if (s_axi_araddr == tcomp_pkg::OFS_OUT_STAT) begin
			next_rdata[5:0] = oc_bits;
			next_rdata[tcomp_pkg::STAT_CONN_LSB +: 6] = conn_bits;
		end else if (is_cmp(s_axi_araddr)) begin
			next_rdata[15:0] = cmp_val[rd_off[4:2]];
		end else begin
			rd_ok = 1'b0;
		end
	end

	// Read channels
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= tcomp_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= rd_ok ? tcomp_pkg::RESP_OKAY : tcomp_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// Waveform class per timer
	for (genvar t = 0; t < 2; t++) begin : g_tmr
		tcomp_wgm_dec u_dec (
			.ref_clk(ref_clk),
			.nrst(nrst),
			.wgm({wgm_hi[t], ctrl_a[t][tcomp_pkg::WGM_LO_MSB -: 2]}),
			.wclass(wclass[t])
		);
	end

	tcomp_chan_if ch [6] ();

	// Three channels per timer
	for (genvar i = 0; i < 6; i++) begin : g_ch
		localparam int T = i / 3;
		localparam int K = i % 3;
		assign ch[i].mode = ctrl_a[T][tcomp_pkg::MODE_MSB[K] -: 2];
		assign ch[i].wclass = wclass[T];
		assign ch[i].wgm_hi = wgm_hi[T][1];
		assign ch[i].is_a = (K == 0);
		assign ch[i].tick = tmr_tick[T];
		assign ch[i].count_up = tmr_count_up[T];
		assign ch[i].match = tmr_tick[T] && (tmr_count[T] == cmp_val[i]);
		assign ch[i].at_top = tmr_tick[T] && (tmr_count[T] == tmr_top[T]);
		assign ch[i].cmp_is_top = (cmp_val[i] == tmr_top[T]);
		assign oc_bits[i] = ch[i].oc;
		assign conn_bits[i] = ch[i].connect;

		tcomp_chan u_chan (
			.ref_clk(ref_clk),
			.nrst(nrst),
			.ch(ch[i])
		);

		// Pin mux and driver enable
		always_ff @(posedge ref_clk or negedge nrst) begin
			if (!nrst) begin
				pin_out[i] <= 1'b0;
				pin_oe_n[i] <= 1'b1;
			end else begin
				pin_out[i] <= ch[i].connect ? ch[i].oc : port_data[i];
				pin_oe_n[i] <= !port_dir[i];
			end
		end

		chk_pin_takeover: assert property (@(posedge ref_clk)
			disable iff (!nrst)
			(ch[i].connect && ch[i].oc) |=> pin_out[i])
			else $error("compare output not on pin");
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	sequence s_dir_write;
		do_write && (aw_addr == tcomp_pkg::OFS_PORT_DIR) && w_strb[0];
	endsequence
	sequence s_ctrl1_write;
		do_write && (aw_addr == tcomp_pkg::OFS_CTRL_A1) && w_strb[0];
	endsequence
	sequence s_read_req;
		s_axi_arvalid && s_axi_arready;
	endsequence

	chk_oe_from_dir: assert property (
		s_dir_write |-> ##2 (pin_oe_n == ~$past(w_data[5:0], 2)))
		else $error("driver enable does not follow direction");
	chk_ctrl_write: assert property (
		s_ctrl1_write |=> (ctrl_a[0] == $past(w_data[7:0])))
		else $error("control A write lost");
	chk_read_answer: assert property (
		s_read_req |=> s_axi_rvalid && !s_axi_arready)
		else $error("read not answered next cycle");
	chk_write_answer: assert property (
		do_write |=> s_axi_bvalid)
		else $error("write not answered");
endmodule : tcomp_top

// ===== src/tcomp_wgm_dec.sv
`timescale 1ns/1ns
module tcomp_wgm_dec (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [3:0] wgm,
	output tcomp_pkg::tcomp_class_t wclass
);
	// Sort the four-bit waveform mode into its class
	always_comb begin
		unique case (wgm)
			4'h0, 4'h4, 4'hC: wclass = tcomp_pkg::TCOMP_NON_PWM;
			4'h5, 4'h6, 4'h7, 4'hE, 4'hF: wclass = tcomp_pkg::TCOMP_FAST;
			4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB: begin
				wclass = tcomp_pkg::TCOMP_PHASE;
			end
			4'hD: wclass = tcomp_pkg::TCOMP_RESERVED;
		endcase
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	chk_reserved_mode: assert property (
		(wgm == 4'hD) |-> (wclass == tcomp_pkg::TCOMP_RESERVED))
		else $error("mode 13 not decoded as reserved");
	chk_nonpwm_modes: assert property (
		(wgm == 4'h0 || wgm == 4'h4 || wgm == 4'hC)
		|-> (wclass == tcomp_pkg::TCOMP_NON_PWM))
		else $error("non-PWM mode misdecoded");
endmodule : tcomp_wgm_dec
